// ---- dtc_channel.sv ----
// Purpose: Package of constants and one 8-bit up-counter channel of the dual timer.
// Assumes: tick is a one-cycle enable on clk already chosen from the source clocks.
// Notes:   The package stands first so that it compiles before all four modules that import it.

package dtc_pkg;
   // ****************************************
   // Register map (byte addresses, 32-bit words)
   // ****************************************
   localparam logic [7:0] CTRL0_ADDR  = 8'h00;
   localparam logic [7:0] CMP0_ADDR   = 8'h04;
   localparam logic [7:0] STAT0_ADDR  = 8'h08;
   localparam logic [7:0] CTRL1_ADDR  = 8'h10;
   localparam logic [7:0] CMP1_ADDR   = 8'h14;
   localparam logic [7:0] STAT1_ADDR  = 8'h18;
   localparam logic [7:0] CFG_ADDR    = 8'h20;
   localparam logic [7:0] CH_STRIDE   = 8'h10;

   // ****************************************
   // Field positions of counter_control_reg
   // ****************************************
   localparam int CTRL_FF_BIT   = 7;
   localparam int CTRL_CLK_HI   = 6;
   localparam int CTRL_CLK_LO   = 4;
   localparam int CTRL_RUN_BIT  = 3;
   localparam int CTRL_MODE_HI  = 2;
   localparam int CTRL_MODE_LO  = 0;
   // Configuration register fields
   localparam int CFG_TAP_BIT   = 0;
   localparam int CFG_SLOW_BIT  = 1;
   // Status register fields
   localparam int STAT_FF_BIT   = 8;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] CMP_RST   = 8'h00;
   localparam logic [1:0] CFG_RST   = 2'h0;
   localparam logic [7:0] CNT_RST   = 8'h00;
   localparam logic       FF_RST    = 1'b0;

   // ****************************************
   // Encodings
   // ****************************************
   localparam logic [2:0] MODE_TIMER = 3'h0;
   localparam logic [2:0] MODE_DIV   = 3'h1;

   typedef enum logic [2:0] {
      DTC_CLK_TAP,
      DTC_CLK_FC7,
      DTC_CLK_FC5,
      DTC_CLK_FC3,
      DTC_CLK_FS,
      DTC_CLK_FC1,
      DTC_CLK_FC,
      DTC_CLK_PIN
   } dtc_clksel_t;

   // ****************************************
   // Timing
   // ****************************************
   localparam int          FC_HZ      = 100_000_000;
   localparam int          FS_HZ      = 32_768;
   // Low-frequency clock is emulated by a divider of clk (rounded down)
   localparam int          FS_DIV_INT = FC_HZ / FS_HZ;
   localparam logic [11:0] FS_DIV     = 12'(FS_DIV_INT);
   localparam int          PRE_W      = 11;
endpackage

module dtc_channel
   import dtc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       run,
   input  wire logic       tick,
   input  wire logic       divMode,
   input  wire logic [7:0] cmpVal,
   input  wire logic       ffLoad,
   input  wire logic       ffLoadVal,
   output logic      [7:0] count,
   output logic            outFf,
   output logic            matchPulse
);
   import dtc_pkg::*;

   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic       ff_ff;
   logic       nxt_ff;
   logic       match_ff;
   logic       nxt_match;
   logic [7:0] incVal;

   // ****************************************
   // Counter, compare and output flip-flop
   // ****************************************
   always_comb begin
      incVal    = cnt_ff + 8'h01;
      nxt_cnt   = cnt_ff;
      nxt_ff    = ff_ff;
      nxt_match = 1'b0;
      if (!run) begin
         nxt_cnt = CNT_RST;
         // Stopping never touches the flip-flop so the pin holds its level
         if (ffLoad) begin
            nxt_ff = ffLoadVal;
         end
      end else begin
         if (ffLoad) begin
            nxt_ff = ffLoadVal;
         end
         // Compare reads cmpVal directly: a new value acts at once
         if (tick) begin
            if (incVal == cmpVal) begin
               nxt_cnt   = CNT_RST;
               nxt_match = 1'b1;
               if (divMode) begin
                  nxt_ff = ~ff_ff;
               end
            end else begin
               nxt_cnt = incVal;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_ff   <= CNT_RST;
         ff_ff    <= FF_RST;
         match_ff <= 1'b0;
      end else begin
         cnt_ff   <= nxt_cnt;
         ff_ff    <= nxt_ff;
         match_ff <= nxt_match;
      end
   end

   assign count      = cnt_ff;
   assign outFf      = ff_ff;
   assign matchPulse = match_ff;
endmodule

// ---- dtc_top.sv ----
// Purpose: Dual 8-bit timer/event counter/divider with an APB register slave.
// Assumes: One 100 MHz clock; fc is clk, fs is derived from clk by a divider.
// Notes:   pready is always high; read data is registered in the setup cycle.

module dtc_top
   import dtc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic      [31:0]      prdata,
   output logic                  pslverr,
   input  wire logic [1:0]       eventInputPin,
   output logic      [1:0]       dividerOutputPin,
   output logic      [1:0]       matchInterrupt
);
   import dtc_pkg::*;

   // ****************************************
   // Register state
   // ****************************************
   logic [7:0]  ctrl_ff   [2];
   logic [7:0]  nxt_ctrl  [2];
   logic [7:0]  cmp_ff    [2];
   logic [7:0]  nxt_cmp   [2];
   logic [1:0]  cfg_ff;
   logic [1:0]  nxt_cfg;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        err_ff;
   logic        nxt_err;
   logic [1:0]  ffLoad;
   logic [7:0]  count     [2];
   logic [1:0]  outFf;

   logic        wrEn;
   logic        setup;
   logic        mapped;

   assign setup  = psel & ~penable;
   assign wrEn   = psel & penable & pwrite;
   assign mapped = (paddr == CTRL0_ADDR) | (paddr == CMP0_ADDR) | (paddr == STAT0_ADDR) |
                   (paddr == CTRL1_ADDR) | (paddr == CMP1_ADDR) | (paddr == STAT1_ADDR) |
                   (paddr == CFG_ADDR);

   // ****************************************
   // APB write decode and read capture
   // ****************************************
   always_comb begin
      nxt_cfg   = cfg_ff;
      nxt_rdata = rdata_ff;
      nxt_err   = err_ff;
      ffLoad    = 2'b00;
      for (int i = 0; i < 2; i++) begin
         nxt_ctrl[i] = ctrl_ff[i];
         nxt_cmp[i]  = cmp_ff[i];
         if (wrEn && paddr == CTRL0_ADDR + CH_STRIDE * 8'(i)) begin
            nxt_ctrl[i] = pwdata[7:0];
            // Flip-flop loads only when the counter was stopped: this covers
            // programming while stopped and together with the start write
            ffLoad[i]   = ~ctrl_ff[i][CTRL_RUN_BIT];
         end
         if (wrEn && paddr == CMP0_ADDR + CH_STRIDE * 8'(i)) begin
            nxt_cmp[i] = pwdata[7:0];
         end
      end
      if (wrEn && paddr == CFG_ADDR) begin
         nxt_cfg = pwdata[1:0];
      end
      if (setup) begin
         nxt_err   = ~mapped;
         nxt_rdata = 32'h0000_0000;
         case (paddr)
            CTRL0_ADDR: nxt_rdata = {24'h00_0000, ctrl_ff[0]};
            CMP0_ADDR:  nxt_rdata = {24'h00_0000, cmp_ff[0]};
            STAT0_ADDR: nxt_rdata = {23'h00_0000, outFf[0], count[0]};
            CTRL1_ADDR: nxt_rdata = {24'h00_0000, ctrl_ff[1]};
            CMP1_ADDR:  nxt_rdata = {24'h00_0000, cmp_ff[1]};
            STAT1_ADDR: nxt_rdata = {23'h00_0000, outFf[1], count[1]};
            CFG_ADDR:   nxt_rdata = {30'h0000_0000, cfg_ff};
            default:    nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 2; i++) begin
            ctrl_ff[i] <= CTRL_RST;
            cmp_ff[i]  <= CMP_RST;
         end
         cfg_ff   <= CFG_RST;
         rdata_ff <= 32'h0000_0000;
         err_ff   <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ctrl_ff[i] <= nxt_ctrl[i];
            cmp_ff[i]  <= nxt_cmp[i];
         end
         cfg_ff   <= nxt_cfg;
         rdata_ff <= nxt_rdata;
         err_ff   <= nxt_err;
      end
   end

   assign pready  = 1'b1;
   assign prdata  = rdata_ff;
   assign pslverr = psel & penable & err_ff;

   // ****************************************
   // Prescaler: fc taps and emulated fs
   // ****************************************
   logic [PRE_W-1:0] pre_ff;
   logic [PRE_W-1:0] nxt_pre;
   logic [11:0]      fsDiv_ff;
   logic [11:0]      nxt_fsDiv;
   logic [2:0]       fs8_ff;
   logic [2:0]       nxt_fs8;
   logic             fsTick;
   logic             fs8Tick;
   logic             fc3Tick;
   logic             fc5Tick;
   logic             fc7Tick;
   logic             fc11Tick;
   logic             fc1Tick;

   always_comb begin
      nxt_pre   = pre_ff + 11'h001;
      fsTick    = (fsDiv_ff == FS_DIV - 12'h001);
      nxt_fsDiv = fsTick ? 12'h000 : fsDiv_ff + 12'h001;
      nxt_fs8   = fsTick ? fs8_ff + 3'h1 : fs8_ff;
      fs8Tick   = fsTick & (fs8_ff == 3'h7);
      fc1Tick   = (pre_ff[0] == 1'b1);
      fc3Tick   = (pre_ff[2:0] == 3'h7);
      fc5Tick   = (pre_ff[4:0] == 5'h1F);
      fc7Tick   = (pre_ff[6:0] == 7'h7F);
      fc11Tick  = (pre_ff == 11'h7FF);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pre_ff   <= 11'h000;
         fsDiv_ff <= 12'h000;
         fs8_ff   <= 3'h0;
      end else begin
         pre_ff   <= nxt_pre;
         fsDiv_ff <= nxt_fsDiv;
         fs8_ff   <= nxt_fs8;
      end
   end

   // ****************************************
   // Event pins: two-stage sync and fall detect
   // ****************************************
   logic [1:0] evSync1_ff;
   logic [1:0] evSync2_ff;
   logic [1:0] evLast_ff;
   logic [1:0] evFall;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evSync1_ff <= 2'b11;
         evSync2_ff <= 2'b11;
         evLast_ff  <= 2'b11;
      end else begin
         evSync1_ff <= eventInputPin;
         evSync2_ff <= evSync1_ff;
         evLast_ff  <= evSync2_ff;
      end
   end

   // Pulses shorter than one clk period may be missed; hence the level width limit
   assign evFall = evLast_ff & ~evSync2_ff;

   // ****************************************
   // Source selection and the two channels
   // ****************************************
   for (genvar g = 0; g < 2; g++) begin : gCh
      dtc_clksel_t sel;
      logic        slowMode;
      logic        modeOk;
      logic        chTick;

      assign sel      = dtc_clksel_t'(ctrl_ff[g][CTRL_CLK_HI:CTRL_CLK_LO]);
      assign slowMode = cfg_ff[CFG_SLOW_BIT];
      assign modeOk   = (ctrl_ff[g][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_TIMER) |
                        (ctrl_ff[g][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_DIV);

      // Each channel drives its own local tick so no variable has two writers
      always_comb begin
         chTick = 1'b0;
         case (sel)
            // Slow modes force the tap to fs/2^3 whatever the tap select says
            DTC_CLK_TAP: chTick = (slowMode | cfg_ff[CFG_TAP_BIT]) ? fs8Tick
                                                                   : fc11Tick;
            DTC_CLK_FC7: chTick = ~slowMode & fc7Tick;
            DTC_CLK_FC5: chTick = ~slowMode & fc5Tick;
            DTC_CLK_FC3: chTick = ~slowMode & fc3Tick;
            // fs, fc/2 and fc serve only PWM, which this block does not build
            DTC_CLK_FS:  chTick = 1'b0;
            DTC_CLK_FC1: chTick = 1'b0;
            DTC_CLK_FC:  chTick = 1'b0;
            DTC_CLK_PIN: chTick = (ctrl_ff[g][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_TIMER)
                                  & evFall[g];
            default:     chTick = 1'b0;
         endcase
      end

      dtc_channel uCh (
         .clk        (clk),
         .sys_rst    (sys_rst),
         .run        (ctrl_ff[g][CTRL_RUN_BIT] & modeOk),
         .tick       (chTick),
         .divMode    (ctrl_ff[g][CTRL_MODE_HI:CTRL_MODE_LO] == MODE_DIV),
         .cmpVal     (cmp_ff[g]),
         .ffLoad     (ffLoad[g]),
         .ffLoadVal  (pwdata[CTRL_FF_BIT]),
         .count      (count[g]),
         .outFf      (outFf[g]),
         .matchPulse (matchInterrupt[g])
      );

      assign dividerOutputPin[g] = ~outFf[g];
   end
endmodule

// ---- dtc_top_asserts.sv ----
// Purpose: Port-level checks of the dual timer block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound onto dtc_top at the foot of this file.
module dtc_top_asserts
   import dtc_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [1:0]  eventInputPin,
   input wire logic [1:0]  dividerOutputPin,
   input wire logic [1:0]  matchInterrupt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ****************************************
   // Bus phases
   // ****************************************
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence

   property p_ready;
      s_setup ##1 s_access |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready low in access");
   property p_badAddr;
      psel && !penable && !pwrite && paddr == 8'h0C ##1 s_access |-> pslverr && prdata == 32'h0;
   endproperty
   a_badAddr: assert property (p_badAddr) else $error("unmapped read not refused");
   property p_goodAddr;
      psel && !penable && paddr == CTRL0_ADDR ##1 s_access |-> !pslverr && prdata[31:8] == 24'h0;
   endproperty
   a_goodAddr: assert property (p_goodAddr) else $error("control access misreported");
   property p_statRsv;
      psel && !penable && !pwrite && paddr == STAT1_ADDR ##1 s_access |-> prdata[31:9] == 23'h0;
   endproperty
   a_statRsv: assert property (p_statRsv) else $error("status reserved bits set");
   property p_errIdle;
      !(psel && penable) |-> !pslverr;
   endproperty
   a_errIdle: assert property (p_errIdle) else $error("pslverr outside access");

   // ****************************************
   // Pins and interrupts
   // ****************************************
   // Reset must clear the flip-flop, so the pin sits high until software acts
   property p_rstVal;
      $fell(sys_rst) |-> dividerOutputPin == 2'h3 && matchInterrupt == 2'h0 ##1 dividerOutputPin == 2'h3;
   endproperty
   a_rstVal: assert property (p_rstVal) else $error("pin or interrupt wrong after reset");
   // Legal inputs never match faster than every eight cycles
   property p_int0;
      matchInterrupt[0] |=> !matchInterrupt[0] [*7];
   endproperty
   a_int0: assert property (p_int0) else $error("channel 0 interrupt too long");
   property p_int1;
      matchInterrupt[1] |=> !matchInterrupt[1] [*7];
   endproperty
   a_int1: assert property (p_int1) else $error("channel 1 interrupt too long");
endmodule

bind dtc_top dtc_top_asserts i_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .eventInputPin(eventInputPin), .dividerOutputPin(dividerOutputPin),
   .matchInterrupt(matchInterrupt));

// ---- testbench.sv ----
// Purpose: Self-checking bench for the dual timer block.
// Assumes: Zero-wait APB slave, 100 MHz clock.
// Notes:   Counts are measured at falling edges, where outputs are settled.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dtc_pkg::*;

   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic [1:0]  eventInputPin = 2'h3;
   logic [1:0]  dividerOutputPin;
   logic [1:0]  matchInterrupt;
   int          errCount = 0;
   int          comparisons = 0;
   int          n;
   logic        hold;
   logic [31:0] cfgs[2] = '{32'h2, 32'h0};
   logic [31:0] ctls[2] = '{32'h38, 32'h3A};

   always #5 clk = ~clk;

   dtc_top i_dtc_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .eventInputPin(eventInputPin), .dividerOutputPin(dividerOutputPin),
      .matchInterrupt(matchInterrupt));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Waits one edge first so no signal is assigned twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      e = pslverr;
      if (k >= 50) begin
         errCount++;
         $display("[FAIL] %0t no pready on the bus", $time);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(q, exp);
      check({31'h0, e}, {31'h0, expErr});
   endtask

   task automatic waitInt(input int ch, output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (matchInterrupt[ch] !== 1'b1 && k < 5000);
      if (k >= 5000) begin
         errCount++;
         $display("[FAIL] %0t no match interrupt on channel %0d", $time, ch);
      end
   endtask

   task automatic waitChange(output int k);
      logic p;
      p = dividerOutputPin[1];
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (dividerOutputPin[1] === p && k < 5000);
   endtask

   // Event levels held ten cycles, above two machine cycles
   task automatic fall;
      @(posedge clk);
      eventInputPin[0] <= 1'b0;
      repeat (10) @(posedge clk);
      eventInputPin[0] <= 1'b1;
      repeat (10) @(posedge clk);
   endtask

   task automatic results;
      $display("Mismatches %0d, comparisons %0d", errCount, comparisons);
      if (errCount == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      errCount++;
      $display("[FAIL] %0t watchdog expired", $time);
      results;
   end

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rdChk(CTRL0_ADDR, 32'h0, 1'b0);
      rdChk(STAT1_ADDR, 32'h0, 1'b0);
      check({30'h0, dividerOutputPin}, 32'h3);
      rdChk(8'h0C, 32'h0, 1'b1);
      wr(CMP0_ADDR, 32'h3);
      wr(CTRL0_ADDR, 32'h38);
      waitInt(0, n);
      waitInt(0, n);
      check(32'(n), 32'h18);
      wr(CTRL0_ADDR, 32'h30);
      wr(CMP0_ADDR, 32'h1);
      wr(CTRL0_ADDR, 32'h08);
      waitInt(0, n);
      waitInt(0, n);
      check(32'(n), 32'h800);
      wr(CTRL0_ADDR, 32'h00);
      wr(CMP0_ADDR, 32'hC8);
      wr(CTRL0_ADDR, 32'h38);
      // A buffered compare would wait for count 200, about 1600 cycles
      wr(CMP0_ADDR, 32'h0A);
      waitInt(0, n);
      check({31'h0, n < 90}, 32'h1);
      wr(CTRL0_ADDR, 32'h30);
      for (int i = 0; i < 2; i++) begin
         wr(CFG_ADDR, cfgs[i]);
         wr(CTRL0_ADDR, ctls[i]);
         repeat (60) @(posedge clk);
         rdChk(STAT0_ADDR, 32'h0, 1'b0);
         wr(CTRL0_ADDR, ctls[i] & 32'hF7);
      end
      wr(CFG_ADDR, 32'h0);
      wr(CMP0_ADDR, 32'h3);
      wr(CTRL0_ADDR, 32'h78);
      fall();
      fall();
      rdChk(STAT0_ADDR, 32'h2, 1'b0);
      @(posedge clk);
      eventInputPin[0] <= 1'b0;
      waitInt(0, n);
      check({31'h0, n < 12}, 32'h1);
      // The low level must still last the full minimum width after the match
      repeat (10) @(posedge clk);
      eventInputPin[0] <= 1'b1;
      rdChk(STAT0_ADDR, 32'h0, 1'b0);
      wr(CMP1_ADDR, 32'h4);
      wr(CTRL1_ADDR, 32'h39);
      waitChange(n);
      waitChange(n);
      check(32'(n), 32'h20);
      waitChange(n);
      check(32'(n), 32'h20);
      waitInt(1, n);
      waitInt(1, n);
      check(32'(n), 32'h20);
      wr(CTRL1_ADDR, 32'h31);
      // A last toggle may land on the stop edge, so look once it has settled
      @(negedge clk);
      hold = dividerOutputPin[1];
      repeat (80) @(posedge clk);
      check({31'h0, dividerOutputPin[1]}, {31'h0, hold});
      wr(CTRL1_ADDR, 32'hB1);
      repeat (3) @(posedge clk);
      check({31'h0, dividerOutputPin[1]}, 32'h0);
      rdChk(STAT1_ADDR, 32'h100, 1'b0);
      check({31'h0, dividerOutputPin[0]}, 32'h1);
      results;
   end
endmodule
